// ---- hw/pcrvf_consts.vh ----
// Constants for the PLL control registers and VCO packet forwarder
// Function
// - Packets sent to the VCO subsystem are sixteen bits long.
// - Link runs from the calibration FSM clock, never above 50 MHz.
// - Two-bit field at bits 14:13 of offset 0Ah picks the link rate.
// - Each write to offset 05h forwards its contents, MSB first; of several writes during one frame only the last is sent.
// - Packet bits 2:0 carry the subsystem ID; the VCO answers to 000b.
// - Packet bits 6:3 carry the four-bit subsystem register index.
// - Packet bits 15:7 carry the nine-bit value to write.
// - Calibration updates only the data field; index must be 0000.
// - Calibration leaves ID and index; host restores index after manual use.
// - Reading offset 00h returns a fixed 24-bit identity word.
// - Writing offset 00h bits 4:0 sets the address read next cycle.
// - Writing 1 to bit 5 of offset 00h resets the host serial logic.
// - Offset 01h bit 0 picks the enable source: pin at 1, bit 1 at 0.
// - Offset 01h bit 1 is the register enable; register resets to 000002h.
// - Offset 01h bits 7:2 keep six blocks powered while the PLL is off.
// - Reading offset 05h returns the packet register, as last written or calibrated.
`ifndef PCRVF_CONSTS_VH
`define PCRVF_CONSTS_VH

// ==========================================================
// Register offsets
`define PCRVF_OFS_ID 5'h00
`define PCRVF_OFS_CTRL 5'h01
`define PCRVF_OFS_PACKET 5'h05
`define PCRVF_OFS_RATE 5'h0a
`define PCRVF_OFS_SWITCH 5'h10

// ==========================================================
// Field positions
`define PCRVF_PTR_MSB 4
`define PCRVF_PTR_LSB 0
`define PCRVF_SOFT_RST_BIT 5
`define PCRVF_SRC_SEL_BIT 0
`define PCRVF_REG_EN_BIT 1
`define PCRVF_KEEP_LSB 2
`define PCRVF_KEEP_MSB 7
`define PCRVF_RATE_MSB 14
`define PCRVF_RATE_LSB 13
`define PCRVF_ID_MSB 2
`define PCRVF_ID_LSB 0
`define PCRVF_IDX_MSB 6
`define PCRVF_IDX_LSB 3
`define PCRVF_VAL_MSB 15
`define PCRVF_VAL_LSB 7

// ==========================================================
// Reset values and widths
`define PCRVF_CTRL_RST 10'h002
`define PCRVF_PACKET_RST 16'h0000
`define PCRVF_RATE_RST 2'h0
`define PCRVF_PACKET_BITS 5'h10
`define PCRVF_LAST_BIT 4'hf

// ==========================================================
// Timing
`define PCRVF_CORE_CLK_MHZ 10
`define PCRVF_LINK_CLK_MAX_MHZ 50

`endif

// ---- hw/pcrvf_link_shifter.v ----
// Serial shifter driving the internal VCO link
`timescale 1ns/1ns
`include "pcrvf_consts.vh"

module pcrvf_link_shifter (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Request
  input wire start,
  input wire [15:0] packet,
  input wire [1:0] rate_sel,
  output wire busy,
  // Link pins
  output reg link_sclk_ff,
  output reg link_sdata_ff,
  output reg link_frame_ff
);

  reg [15:0] shift_ff;
  reg [3:0] bit_cnt_ff;
  reg [2:0] div_cnt_ff;
  wire [3:0] half_period;
  wire tick;

  // ==========================================================
  // Rate divider
  // Half period is 1, 2, 4 or 8 core cycles; core clock sits far
  // below the 50 MHz link ceiling, so every setting is legal
  assign half_period = 4'h1 << rate_sel;
  // Four bits wide so the slowest setting of 8 does not wrap to 0
  assign tick = link_frame_ff &&
                ({1'b0, div_cnt_ff} == half_period - 4'h1);
  assign busy = link_frame_ff;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 3'h0;
    end else if (start || tick || !link_frame_ff) begin
      div_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  // ==========================================================
  // Shift engine: data changes while clock low, sampled on rise
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      link_sclk_ff <= 1'b0;
      link_sdata_ff <= 1'b0;
      link_frame_ff <= 1'b0;
    end else if (start && !link_frame_ff) begin
      shift_ff <= {packet[14:0], 1'b0};
      link_sdata_ff <= packet[15];
      bit_cnt_ff <= 4'h0;
      link_sclk_ff <= 1'b0;
      link_frame_ff <= 1'b1;
    end else if (tick) begin
      if (!link_sclk_ff) begin
        link_sclk_ff <= 1'b1;
      end else begin
        link_sclk_ff <= 1'b0;
        if (bit_cnt_ff == `PCRVF_LAST_BIT) begin
          link_frame_ff <= 1'b0;
          link_sdata_ff <= 1'b0;
        end else begin
          link_sdata_ff <= shift_ff[15];
          shift_ff <= {shift_ff[14:0], 1'b0};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
      end
    end
  end

endmodule

// ---- hw/pcrvf_top.v ----
// PLL control registers and VCO packet forwarder top
`timescale 1ns/1ns
`include "pcrvf_consts.vh"

module pcrvf_top #(
  // Identity word, value arbitrary
  parameter [23:0] IDENTITY_WORD = 24'h5a5a01
) (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Register write port
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [23:0] wr_data,
  // Register read port
  input wire rd_en,
  input wire rd_use_pointer,
  input wire [4:0] rd_addr,
  output reg [23:0] rd_data_ff,
  output reg rd_valid_ff,
  output reg [4:0] read_pointer_ff,
  output reg soft_reset_ff,
  // Calibration data updates
  input wire cal_update,
  input wire [8:0] cal_value,
  // Device pins and status
  input wire chip_enable_pin,
  input wire [7:0] vco_switch_settings,
  output reg pll_enable_ff,
  output reg [5:0] block_power_ff,
  // Internal VCO link
  output wire link_sclk,
  output wire link_sdata,
  output wire link_frame,
  output reg link_pending_ff
);

  reg [9:0] ctrl_ff;
  reg [15:0] packet_ff;
  reg [1:0] rate_ff;
  reg [23:0] nxt_rd_data;
  wire [4:0] eff_rd_addr;
  wire host_pkt_wr;
  wire cal_pkt_wr;
  wire pkt_event;
  wire busy;
  wire start;
  wire pll_en_now;

  assign host_pkt_wr = wr_en && (wr_addr == `PCRVF_OFS_PACKET);
  assign cal_pkt_wr = cal_update && !host_pkt_wr;
  assign pkt_event = host_pkt_wr || cal_pkt_wr;
  assign start = link_pending_ff && !busy;

  // ==========================================================
  // Write side registers
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `PCRVF_CTRL_RST;
      rate_ff <= `PCRVF_RATE_RST;
      read_pointer_ff <= 5'h00;
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= 1'b0;
      if (wr_en) begin
        case (wr_addr)
          `PCRVF_OFS_ID: begin
            // Undefined upper bits are dropped
            read_pointer_ff <= wr_data[`PCRVF_PTR_MSB:`PCRVF_PTR_LSB];
            soft_reset_ff <= wr_data[`PCRVF_SOFT_RST_BIT];
          end
          `PCRVF_OFS_CTRL: begin
            ctrl_ff <= wr_data[9:0];
          end
          `PCRVF_OFS_RATE: begin
            rate_ff <= wr_data[`PCRVF_RATE_MSB:`PCRVF_RATE_LSB];
          end
          default: begin
            ctrl_ff <= ctrl_ff;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Packet register: host writes whole word, calibration only data
  // The ID and index fields are never touched by calibration, so a
  // stale index after manual access misroutes calibration data
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      packet_ff <= `PCRVF_PACKET_RST;
    end else if (host_pkt_wr) begin
      packet_ff <= wr_data[15:0];
    end else if (cal_pkt_wr) begin
      packet_ff <= {cal_value, packet_ff[`PCRVF_IDX_MSB:0]};
    end
  end

  // ==========================================================
  // Forward request: new write while busy waits, newest value wins
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_pending_ff <= 1'b0;
    end else if (pkt_event) begin
      link_pending_ff <= 1'b1;
    end else if (start) begin
      link_pending_ff <= 1'b0;
    end
  end

  pcrvf_link_shifter u_shifter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(start),
    .packet(packet_ff),
    .rate_sel(rate_ff),
    .busy(busy),
    .link_sclk_ff(link_sclk),
    .link_sdata_ff(link_sdata),
    .link_frame_ff(link_frame)
  );

  // ==========================================================
  // Read mux
  assign eff_rd_addr = rd_use_pointer ? read_pointer_ff : rd_addr;

  always @* begin
    nxt_rd_data = 24'h000000;
    case (eff_rd_addr)
      `PCRVF_OFS_ID: nxt_rd_data = IDENTITY_WORD;
      `PCRVF_OFS_CTRL: nxt_rd_data = {14'h0000, ctrl_ff};
      `PCRVF_OFS_PACKET: nxt_rd_data = {8'h00, packet_ff};
      `PCRVF_OFS_RATE: nxt_rd_data = {9'h000, rate_ff, 13'h0000};
      `PCRVF_OFS_SWITCH: nxt_rd_data = {16'h0000, vco_switch_settings};
      default: nxt_rd_data = 24'h000000;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= 24'h000000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_en) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // ==========================================================
  // Enable source and per-block power hold
  assign pll_en_now = ctrl_ff[`PCRVF_SRC_SEL_BIT] ? chip_enable_pin :
                      ctrl_ff[`PCRVF_REG_EN_BIT];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_enable_ff <= 1'b0;
    end else begin
      pll_enable_ff <= pll_en_now;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_power
      // Hold bit overrides the enable only while the PLL is off
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          block_power_ff[gi] <= 1'b0;
        end else begin
          block_power_ff[gi] <= pll_en_now ||
                                ctrl_ff[`PCRVF_KEEP_LSB + gi];
        end
      end
    end
  endgenerate

endmodule

// ---- verification/pcrvf_asserts.sv ----
// Port assertions for the PLL control registers and VCO forwarder
`timescale 1ns/1ns
module pcrvf_asserts #(
  parameter [23:0] IDENTITY_WORD = 24'h5a5a01
) (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Host side
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [23:0] wr_data,
  input wire rd_en,
  input wire rd_use_pointer,
  input wire [4:0] rd_addr,
  input wire [23:0] rd_data_ff,
  input wire rd_valid_ff,
  input wire [4:0] read_pointer_ff,
  input wire soft_reset_ff,
  // Power and link
  input wire pll_enable_ff,
  input wire [5:0] block_power_ff,
  input wire link_sclk,
  input wire link_sdata,
  input wire link_frame,
  input wire link_pending_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  reg [4:0] rise_cnt_ff;
  // ==========================================================
  // Clock rises per frame, cleared between frames
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      rise_cnt_ff <= 5'h00;
    else if (!link_frame)
      rise_cnt_ff <= 5'h00;
    else if ($rose(link_sclk))
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
  end
  // ==========================================================
  // Relations between ports
  a_read_latency: assert property (rd_en |=> rd_valid_ff)
    else $error("read answer missing");
  a_id_word: assert property (rd_en && !rd_use_pointer &&
    rd_addr == 5'h00 |=> rd_data_ff == IDENTITY_WORD)
    else $error("identity word wrong");
  a_ptr_load: assert property (wr_en && wr_addr == 5'h00
    |=> read_pointer_ff == $past(wr_data[4:0]))
    else $error("read pointer not loaded");
  a_soft_pulse: assert property (wr_en && wr_addr == 5'h00
    |=> soft_reset_ff == $past(wr_data[5]))
    else $error("soft reset pulse wrong");
  a_fwd_start: assert property (wr_en && wr_addr == 5'h05 &&
    !link_frame && !link_pending_ff |=> link_pending_ff ##1 link_frame)
    else $error("forward did not start");
  a_sclk_idle: assert property (!link_frame |-> !link_sclk)
    else $error("link clock runs outside frame");
  a_data_hold: assert property (link_sclk |-> $stable(link_sdata))
    else $error("link data moved while clock high");
  a_sixteen_bits: assert property ($fell(link_frame)
    |-> rise_cnt_ff == 5'h10)
    else $error("frame bit count wrong");
  a_power_on: assert property (pll_enable_ff |-> &block_power_ff)
    else $error("block off while enabled");
endmodule
bind pcrvf_top pcrvf_asserts #(.IDENTITY_WORD(IDENTITY_WORD)) chk_u (.*);

// ---- verification/pcrvf_vco_model.sv ----
// Behavioural packet decoder at the VCO end of the link
`timescale 1ns/1ns
module pcrvf_vco_model (
  // Link pins
  input wire link_sclk,
  input wire link_sdata,
  input wire link_frame,
  // Decoded packet
  output reg [15:0] last_pkt_ff,
  output reg [7:0] pkt_cnt_ff = 8'h00,
  output wire [2:0] target_subsystem_id,
  output wire [8:0] subsystem_write_value
);
  reg [15:0] shift_ff;
  reg in_frame = 1'b0;
  // ==========================================================
  // Shift in on the rising clock, first bit lands on top
  always @(posedge link_sclk) begin
    if (link_frame)
      shift_ff <= {shift_ff[14:0], link_sdata};
  end
  // Latch the packet when a frame closes; the first settling of the
  // frame flop out of reset is not a frame and is skipped
  always @(link_frame) begin
    if (link_frame === 1'b1) begin
      in_frame = 1'b1;
    end else if (in_frame) begin
      in_frame = 1'b0;
      last_pkt_ff <= shift_ff;
      pkt_cnt_ff <= pkt_cnt_ff + 8'h01;
    end
  end
  // Field split
  assign target_subsystem_id = last_pkt_ff[2:0];
  assign subsystem_write_value = last_pkt_ff[15:7];
endmodule

// ---- verification/pcrvf_top_tb.sv ----
// Self-checking bench for the PLL control registers and VCO forwarder
`timescale 1ns/1ns
module pcrvf_top_tb;
  reg core_clk, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, cal_update = 1'b0;
  reg rd_use_pointer = 1'b0, chip_enable_pin = 1'b0;
  reg [4:0] wr_addr = 5'h00, rd_addr = 5'h00;
  reg [23:0] wr_data = 24'h000000;
  reg [8:0] cal_value = 9'h000;
  reg [7:0] vco_switch_settings = 8'ha5;
  wire [23:0] rd_data_ff;
  wire [4:0] read_pointer_ff;
  wire [5:0] block_power_ff;
  wire [15:0] last_pkt_ff;
  wire [7:0] pkt_cnt_ff;
  wire [2:0] target_subsystem_id;
  wire [8:0] subsystem_write_value;
  wire rd_valid_ff, soft_reset_ff, pll_enable_ff, link_sclk, link_sdata;
  wire link_frame, link_pending_ff;
  integer error_cnt = 0, n_compared = 0, i, len;
  reg [52:0] rows [0:5];
  pcrvf_top dut_u (.*);
  pcrvf_vco_model vco_u (.*);
  // ==========================================================
  // Shared tasks
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [23:0] d);
    begin
      @(posedge core_clk) {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
      @(posedge core_clk) wr_en <= 1'b0;
      #1;
    end
  endtask
  task rd(input p, input [4:0] a);
    begin
      @(posedge core_clk) {rd_en, rd_use_pointer, rd_addr} <= {2'b11 & {1'b1, p}, a};
      @(posedge core_clk) rd_en <= 1'b0;
      #1;
    end
  endtask
  // Wait for a frame, then count its length in core cycles
  task frame;
    begin
      for (len = 0; link_frame !== 1'b1 && len < 40; len = len + 1)
        @(posedge core_clk) #1;
      for (len = 0; link_frame === 1'b1 && len < 300; len = len + 1)
        @(posedge core_clk) #1;
    end
  endtask
  task results;
    begin
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ==========================================================
  // Clock and watchdog; the run needs well under 0.5 ms
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    results;
  end
  // ==========================================================
  // Main sequence
  initial begin
    rows[0] = {5'h01, 24'h0003fc, 24'h0003fc};
    rows[1] = {5'h0a, 24'hffffff, 24'h006000};
    rows[2] = {5'h03, 24'h123456, 24'h000000};
    rows[3] = {5'h10, 24'h0000ff, 24'h0000a5};
    rows[4] = {5'h00, 24'h000000, 24'h5a5a01};
    rows[5] = {5'h05, 24'h00a500, 24'h00a500};
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(1'b0, 5'h01);
    chk(rd_data_ff, 24'h000002);
    chk(pll_enable_ff, 1'b1);
    chk(rd_valid_ff, 1'b1);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][52:48], rows[i][47:24]);
      rd(1'b0, rows[i][52:48]);
      chk(rd_data_ff, rows[i][23:0]);
    end
    frame;
    chk(last_pkt_ff, 16'ha500);
    chk(target_subsystem_id, 3'h0);
    chk(subsystem_write_value, 9'h14a);
    chk({pll_enable_ff, block_power_ff}, 7'h3f);
    wr(5'h01, 24'h000001);
    @(posedge core_clk) chip_enable_pin <= 1'b1;
    #1;
    chk({pll_enable_ff, block_power_ff}, 7'h00);
    @(posedge core_clk) #1;
    chk(pll_enable_ff, 1'b1);
    $display("row and enable tests done");
    wr(5'h00, 24'h000010);
    chk(read_pointer_ff, 5'h10);
    rd(1'b1, 5'h00);
    chk(rd_data_ff, 24'h0000a5);
    wr(5'h00, 24'h000020);
    chk(soft_reset_ff, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h0a, i << 13);
      wr(5'h05, 24'h00c3a5 ^ i);
      frame;
      chk(len, 24'd32 << i);
      chk(last_pkt_ff, 16'hc3a5 ^ i);
    end
    wr(5'h0a, 24'h000000);
    wr(5'h05, 24'h001234);
    wr(5'h05, 24'h00a502);
    frame;
    chk(last_pkt_ff, 16'h1234);
    frame;
    chk(last_pkt_ff, 16'ha502);
    @(posedge core_clk) {cal_update, cal_value} <= {1'b1, 9'h1ff};
    @(posedge core_clk) cal_update <= 1'b0;
    frame;
    rd(1'b0, 5'h05);
    chk(last_pkt_ff, 16'hff82);
    chk(rd_data_ff, 24'h00ff82);
    chk(pkt_cnt_ff, 8'h08);
    $display("pointer, link and calibration tests done");
    // Reset in mid-frame cuts the link and restores the defaults
    wr(5'h0a, 24'h006000);
    wr(5'h05, 24'h0011b0);
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b0;
    #1;
    chk({link_frame, link_sclk, link_pending_ff, pll_enable_ff}, 4'h0);
    chk(block_power_ff, 6'h00);
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(1'b0, 5'h0a);
    chk(rd_data_ff, 24'h000000);
    rd(1'b0, 5'h01);
    chk(rd_data_ff, 24'h000002);
    wr(5'h05, 24'h0011b0);
    frame;
    chk(len, 24'd32);
    chk(last_pkt_ff, 16'h11b0);
    $display("mid-run reset test done");
    results;
  end
endmodule
